// File: verilog/ext_bus_strobes.sv
// Operation
// - Space selects idle high; only the accessed space goes low
// - Strobes float only when emu1 low, test reset low, emulation_pin_zero high
// - Direction qualifier high for reads, low only during writes
// - Write/read qualifier is the inverse of the direction qualifier
// - Write/read qualifier low except during a write to any space
// - Read strobe active on every external read of any space
// - Write strobe active on every external write of any space
// - Data bus driven from the falling edge of the write strobe
// - Bus-cycle strobe idle high, low on every off-chip access
// - Shared qualifier pin comes up as an input when used as I/O
//
// Purpose: Control strobes of the external memory and I/O bus
// Assumes: One request pulse per access, taken only when ready
// Notes: Three-phase access: setup, strobe, hold, one clock each
`timescale 1ns/1ps
module ext_bus_strobes
   import ext_bus_pkg::*;
#(
   parameter int DW = DATA_WIDTH
)
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic REQ_I,
   input wire logic REQ_WRITE_I,
   input wire logic [1:0] REQ_SPACE_I,
   input wire logic [DW-1:0] WRITE_DATA_I,
   input wire logic [DW-1:0] DATA_IN_I,
   input wire logic EMULATION_PIN_ONE_FLOAT_I,
   input wire logic EMULATION_PIN_ZERO_I,
   input wire logic TEST_RESET_I,
   input wire logic PORT_C_BIT0_MODE_I,
   input wire logic PORT_C_BIT0_DIR_I,
   input wire logic PORT_C_BIT0_OUT_I,
   input wire logic PORT_C_BIT0_GPIO_I,
   output logic READY_O,
   output logic DONE_O,
   output logic [DW-1:0] READ_DATA_O,
   output logic PROGRAM_SPACE_SELECT_N_O,
   output logic DATA_SPACE_SELECT_N_O,
   output logic IO_SPACE_SELECT_N_O,
   output logic BUS_CYCLE_STROBE_N_O,
   output logic READ_STROBE_N_O,
   output logic WRITE_STROBE_N_O,
   output logic READ_WRITE_N_O,
   output logic CONTROL_OE_O,
   output logic [DW-1:0] DATA_OUT_O,
   output logic DATA_OE_O,
   output logic PORT_C_BIT0_GPIO_O,
   output logic PORT_C_BIT0_GPIO_OE_O,
   output logic PORT_C_BIT0_GPIO_IN_O
);
   //***************************************************
   // Declarations
   //***************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_HOLD = 2'b11
   } bus_state_e;

   bus_state_e state;
   bus_state_e next_state;
   logic [3:0] count;
   logic [3:0] next_count;
   logic is_write;
   logic next_is_write;
   logic [1:0] space;
   logic [1:0] next_space;
   logic [DW-1:0] wdata;
   logic [DW-1:0] next_wdata;
   logic float_now;
   logic gpio_oe;
   logic gpio_drive;
   logic gpio_in;
   logic active;
   logic in_strobe;

   logic next_ready;
   logic next_done;
   logic [DW-1:0] next_rdata;
   logic next_ps_n;
   logic next_ds_n;
   logic next_is_n;
   logic next_bus_cycle_strobe_n_n;
   logic next_rd_n;
   logic next_we_n;
   logic next_rw;
   logic [DW-1:0] next_dout;
   logic next_doe;
   logic next_wr_q;
   logic next_wr_oe;
   logic next_ctl_oe;

   //***************************************************
   // Helpers
   //***************************************************
   float_decode u_float (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .emulation_pin_one_float_i(EMULATION_PIN_ONE_FLOAT_I),
      .emulation_pin_zero_i(EMULATION_PIN_ZERO_I),
      .test_reset_i(TEST_RESET_I),
      .float_o(float_now)
   );

   gpio_pin u_gpio (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .gpio_mode_i(PORT_C_BIT0_MODE_I),
      .gpio_dir_i(PORT_C_BIT0_DIR_I),
      .gpio_out_i(PORT_C_BIT0_OUT_I),
      .pin_i(PORT_C_BIT0_GPIO_I),
      .gpio_in_o(gpio_in),
      .gpio_oe_o(gpio_oe),
      .gpio_drive_o(gpio_drive)
   );

   //***************************************************
   // Access sequencer
   //***************************************************
   // Next state, counter and latched request
   always_comb begin
      next_state = state;
      next_count = count;
      next_is_write = is_write;
      next_space = space;
      next_wdata = wdata;
      case (state)
         ST_IDLE: begin
            // Request latched so the strobes follow a stable command
            // Taken only with READY_O shown, never on the first edge
            if (REQ_I && READY_O) begin
               next_state = ST_SETUP;
               next_count = SETUP_CYCLES;
               next_is_write = REQ_WRITE_I;
               next_space = REQ_SPACE_I;
               next_wdata = WRITE_DATA_I;
            end
         end
         ST_SETUP: begin
            if (count <= 4'h1) begin
               next_state = ST_STROBE;
               next_count = STROBE_CYCLES;
            end else begin
               next_count = count - 4'h1;
            end
         end
         ST_STROBE: begin
            if (count <= 4'h1) begin
               next_state = ST_HOLD;
            end else begin
               next_count = count - 4'h1;
            end
         end
         ST_HOLD: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state <= ST_IDLE;
         count <= 4'h0;
         is_write <= 1'b0;
         space <= SPACE_PROGRAM;
         wdata <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
         is_write <= next_is_write;
         space <= next_space;
         wdata <= next_wdata;
      end
   end

   //***************************************************
   // Phase decode
   //***************************************************
   // Pins follow next_state, so each level changes on the
   // same edge as the phase itself and needs no extra lag
   always_comb begin
      active = (next_state != ST_IDLE);
      in_strobe = (next_state == ST_STROBE);
   end

   //***************************************************
   // Control pins
   //***************************************************
   // Next control levels from the sequencer state
   always_comb begin
      next_ready = (next_state == ST_IDLE);
      next_done = (state == ST_HOLD);
      next_bus_cycle_strobe_n_n = active ? 1'b0 : STROBE_IDLE;
      // one space select; at most one; inside strobe
      next_ps_n = !(active && next_space == SPACE_PROGRAM);
      next_ds_n = !(active && next_space == SPACE_DATA);
      next_is_n = !(active && next_space == SPACE_IO);
      // read strobe; exclusive with write strobe
      next_rd_n = !(in_strobe && !next_is_write);
      next_we_n = !(in_strobe && next_is_write);
      // direction qualifier low only on writes
      next_rw = (active && next_is_write) ? 1'b0 : DIR_READ;
      // float only on the emulation condition
      next_ctl_oe = !float_now;
   end

   // Idle levels at reset; the float enable passes two flops,
   // a known two-clock lag behind the emulation pins
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         READY_O <= 1'b0;
         DONE_O <= 1'b0;
         PROGRAM_SPACE_SELECT_N_O <= STROBE_IDLE;
         DATA_SPACE_SELECT_N_O <= STROBE_IDLE;
         IO_SPACE_SELECT_N_O <= STROBE_IDLE;
         BUS_CYCLE_STROBE_N_O <= STROBE_IDLE;
         READ_STROBE_N_O <= STROBE_IDLE;
         WRITE_STROBE_N_O <= STROBE_IDLE;
         READ_WRITE_N_O <= DIR_READ;
         CONTROL_OE_O <= 1'b1;
      end else begin
         READY_O <= next_ready;
         DONE_O <= next_done;
         PROGRAM_SPACE_SELECT_N_O <= next_ps_n;
         DATA_SPACE_SELECT_N_O <= next_ds_n;
         IO_SPACE_SELECT_N_O <= next_is_n;
         BUS_CYCLE_STROBE_N_O <= next_bus_cycle_strobe_n_n;
         READ_STROBE_N_O <= next_rd_n;
         WRITE_STROBE_N_O <= next_we_n;
         READ_WRITE_N_O <= next_rw;
         CONTROL_OE_O <= next_ctl_oe;
      end
   end

   //***************************************************
   // Data bus
   //***************************************************
   // Next data bus drive and captured read word
   always_comb begin
      next_rdata = READ_DATA_O;
      // data driven from write strobe fall until hold ends
      next_doe = next_is_write &&
         (next_state == ST_STROBE || next_state == ST_HOLD);
      next_dout = next_wdata;
      // Capture read data as the strobe phase ends
      if (state == ST_STROBE && next_state == ST_HOLD && !is_write) begin
         next_rdata = DATA_IN_I;
      end
   end

   // Bus released at reset so no external device fights it
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         READ_DATA_O <= '0;
         DATA_OUT_O <= '0;
         DATA_OE_O <= 1'b0;
      end else begin
         READ_DATA_O <= next_rdata;
         DATA_OUT_O <= next_dout;
         DATA_OE_O <= next_doe;
      end
   end

   //***************************************************
   // Shared qualifier pin
   //***************************************************
   // inverse qualifier; high only during writes
   always_comb begin
      if (PORT_C_BIT0_MODE_I) begin
         next_wr_q = gpio_drive;
         next_wr_oe = gpio_oe;
      end else begin
         // Not a floated pin, so it keeps driving the qualifier
         next_wr_q = !next_rw;
         next_wr_oe = 1'b1;
      end
   end

   // shared pin is input after reset
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PORT_C_BIT0_GPIO_O <= GPIO_OUT_RESET;
         PORT_C_BIT0_GPIO_OE_O <= GPIO_DIR_RESET;
         PORT_C_BIT0_GPIO_IN_O <= 1'b0;
      end else begin
         PORT_C_BIT0_GPIO_O <= next_wr_q;
         PORT_C_BIT0_GPIO_OE_O <= next_wr_oe;
         PORT_C_BIT0_GPIO_IN_O <= gpio_in;
      end
   end
endmodule

// File: verilog/ext_bus_pkg.sv
// Purpose: Constants shared by the external bus strobe generator
// Assumes: 10 MHz processor clock, one access phase per clock
// Notes: Space and direction codes used by the core request port
package ext_bus_pkg;
   // Address space codes on the request port
   localparam logic [1:0] SPACE_PROGRAM = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO = 2'h2;
   // Idle levels of the strobes
   localparam logic STROBE_IDLE = 1'h1;
   localparam logic DIR_READ = 1'h1;
   // Reset value of the shared port pin direction (input)
   localparam logic GPIO_DIR_RESET = 1'h0;
   localparam logic GPIO_OUT_RESET = 1'h0;
   // Cycle counts: setup phase, strobe phase (hold has no constant, one clock)
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETUP_NS = 100;
   localparam int STROBE_NS = 100;
   localparam logic [3:0] SETUP_CYCLES =
      4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_CYCLES =
      4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int DATA_WIDTH = 16;
endpackage

// File: verilog/float_decode.sv
// Purpose: Decode the emulation pins into a strobe float condition
// Assumes: Inputs synchronous to the clock
// Notes: Registered so the float enable changes on clock edges only
`timescale 1ns/1ps
module float_decode
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic emulation_pin_one_float_i,
   input wire logic emulation_pin_zero_i,
   input wire logic test_reset_i,
   output logic float_o
);
   logic next_float;

   // Float only in the one documented pin combination
   always_comb begin
      next_float = !emulation_pin_one_float_i && !test_reset_i &&
         emulation_pin_zero_i;
   end

   // Register the condition
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         float_o <= 1'b0;
      end else begin
         float_o <= next_float;
      end
   end
endmodule

// File: verilog/gpio_pin.sv
// Purpose: Shared port pin: write/read qualifier or general I/O
// Assumes: Pin mode and direction come from the core
// Notes: Comes up as an input after reset
`timescale 1ns/1ps
module gpio_pin
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic gpio_mode_i,
   input wire logic gpio_dir_i,
   input wire logic gpio_out_i,
   input wire logic pin_i,
   output logic gpio_in_o,
   output logic gpio_oe_o,
   output logic gpio_drive_o
);
   logic next_oe;
   logic next_drive;
   logic next_in;

   // Next pin control for general I/O use
   always_comb begin
      next_oe = gpio_mode_i && gpio_dir_i;
      next_drive = gpio_out_i;
      next_in = pin_i;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         gpio_oe_o <= GPIO_DIR_RESET;
         gpio_drive_o <= GPIO_OUT_RESET;
         gpio_in_o <= 1'b0;
      end else begin
         gpio_oe_o <= next_oe;
         gpio_drive_o <= next_drive;
         gpio_in_o <= next_in;
      end
   end
endmodule

// File: verification/ext_bus_chk.sv
// Purpose: Port-level assertions for the external bus strobes
// Assumes: One clock domain, reset asynchronous and active high
// Notes: Bound to the top module after the module body
`timescale 1ns/1ps
module ext_bus_chk (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic REQ_I,
   input wire logic REQ_WRITE_I,
   input wire logic EMULATION_PIN_ONE_FLOAT_I,
   input wire logic EMULATION_PIN_ZERO_I,
   input wire logic TEST_RESET_I,
   input wire logic PORT_C_BIT0_MODE_I,
   input wire logic READY_O,
   input wire logic DONE_O,
   input wire logic PROGRAM_SPACE_SELECT_N_O,
   input wire logic DATA_SPACE_SELECT_N_O,
   input wire logic IO_SPACE_SELECT_N_O,
   input wire logic BUS_CYCLE_STROBE_N_O,
   input wire logic READ_STROBE_N_O,
   input wire logic WRITE_STROBE_N_O,
   input wire logic READ_WRITE_N_O,
   input wire logic CONTROL_OE_O,
   input wire logic DATA_OE_O,
   input wire logic PORT_C_BIT0_GPIO_O
);
   // ***************************
   // Assertions
   // ***************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   logic [2:0] sel_n;
   logic flt;
   assign sel_n = {PROGRAM_SPACE_SELECT_N_O, DATA_SPACE_SELECT_N_O,
      IO_SPACE_SELECT_N_O};
   // Float needs all three pin levels at once
   assign flt = !EMULATION_PIN_ONE_FLOAT_I && !TEST_RESET_I &&
      EMULATION_PIN_ZERO_I;
   sequence s_take;
      READY_O && REQ_I;
   endsequence
   sequence s_walk;
      ##1 !BUS_CYCLE_STROBE_N_O ##1 !(READ_STROBE_N_O && WRITE_STROBE_N_O)
      ##1 (READ_STROBE_N_O && WRITE_STROBE_N_O)
      ##1 (BUS_CYCLE_STROBE_N_O && DONE_O);
   endsequence
   a_access_walk: assert property (s_take |-> s_walk)
      else $error("access phases out of order");
   a_one_select: assert property ($onehot0(~sel_n))
      else $error("two space selects low");
   a_no_rd_wr: assert property (READ_STROBE_N_O || WRITE_STROBE_N_O)
      else $error("read and write strobes together");
   a_inside_strobe: assert property ((!READ_STROBE_N_O || !WRITE_STROBE_N_O
      || !READ_WRITE_N_O || sel_n != 3'h7) |-> !BUS_CYCLE_STROBE_N_O)
      else $error("control active outside bus cycle");
   a_read_strobe: assert property (s_take ##0 !REQ_WRITE_I |->
      ##2 (!READ_STROBE_N_O && READ_WRITE_N_O))
      else $error("read strobe missing");
   a_write_strobe: assert property (s_take ##0 REQ_WRITE_I |->
      ##2 (!WRITE_STROBE_N_O && !READ_WRITE_N_O))
      else $error("write strobe missing");
   a_data_drive: assert property ($fell(WRITE_STROBE_N_O) |-> DATA_OE_O)
      else $error("data bus not driven at write");
   a_qual_inverse: assert property ((!PORT_C_BIT0_MODE_I && !$past(
      PORT_C_BIT0_MODE_I)) |-> PORT_C_BIT0_GPIO_O == !READ_WRITE_N_O)
      else $error("write qualifier not inverse");
   a_float_on: assert property (flt ##1 flt |=> !CONTROL_OE_O)
      else $error("strobes not floated");
   a_float_off: assert property (!flt ##1 !flt |=> CONTROL_OE_O)
      else $error("strobes floated wrongly");
endmodule
bind ext_bus_strobes ext_bus_chk u_ext_bus_chk (.*);

// File: verification/ext_memory_model.sv
// Purpose: External memory with one word per space
// Assumes: Reads answer while the read strobe is low
// Notes: Undriven bus shows the inverse of its last value
`timescale 1ns/1ps
module ext_memory_model (
   input wire logic clk_i,
   input wire logic [2:0] sel_n_i,
   input wire logic rd_n_i,
   input wire logic we_n_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o
);
   logic [15:0] mem [3];
   logic [15:0] last;
   int idx;
   // Map the low select to a word; none selected maps to word 2, gated off below
   always_comb idx = sel_n_i == 3'h3 ? 0 : sel_n_i == 3'h5 ? 1 : 2;
   initial last = 16'h0000;
   // Capture write data while the strobe is low
   always @(posedge clk_i) begin
      if (!we_n_i && sel_n_i != 3'h7) mem[idx] <= data_i;
      if (!rd_n_i && sel_n_i != 3'h7) last <= mem[idx];
   end
   // Word stands for the whole read strobe; released bus
   // shows the inverse of the last word read
   always_comb data_o = (!rd_n_i && sel_n_i != 3'h7) ? mem[idx] : ~last;
endmodule

// File: verification/ext_bus_strobes_bench.sv
// Purpose: Self-checking bench for the external bus strobes
// Assumes: Inputs change 1 ns after the rising edge
// Notes: One task per scenario
`timescale 1ns/1ps
module ext_bus_strobes_bench;
   import ext_bus_pkg::*;
   logic clk = 0, rst = 1, req = 0, wr = 0, e1 = 1, e0 = 0, trst = 0;
   logic mode = 0, dir = 0, gout = 0, pin = 0;
   logic [1:0] sp = 0;
   logic [15:0] wd = 0, din, rdat, dout;
   logic rdy, done, ps, ds, is, st, rd, we, rw, coe, doe, go, goe, gin;
   int errors = 0, num_checks = 0, cyc = 0;
   ext_bus_strobes u_ext_bus_strobes (.CLK_I(clk), .RESET_I(rst),
      .REQ_I(req), .REQ_WRITE_I(wr), .REQ_SPACE_I(sp), .WRITE_DATA_I(wd),
      .DATA_IN_I(din), .EMULATION_PIN_ONE_FLOAT_I(e1),
      .EMULATION_PIN_ZERO_I(e0), .TEST_RESET_I(trst),
      .PORT_C_BIT0_MODE_I(mode), .PORT_C_BIT0_DIR_I(dir),
      .PORT_C_BIT0_OUT_I(gout), .PORT_C_BIT0_GPIO_I(pin), .READY_O(rdy),
      .DONE_O(done), .READ_DATA_O(rdat), .PROGRAM_SPACE_SELECT_N_O(ps),
      .DATA_SPACE_SELECT_N_O(ds), .IO_SPACE_SELECT_N_O(is),
      .BUS_CYCLE_STROBE_N_O(st), .READ_STROBE_N_O(rd),
      .WRITE_STROBE_N_O(we), .READ_WRITE_N_O(rw), .CONTROL_OE_O(coe),
      .DATA_OUT_O(dout), .DATA_OE_O(doe), .PORT_C_BIT0_GPIO_O(go),
      .PORT_C_BIT0_GPIO_OE_O(goe), .PORT_C_BIT0_GPIO_IN_O(gin));
   ext_memory_model u_ext_memory_model (.clk_i(clk),
      .sel_n_i({ps, ds, is}), .rd_n_i(rd), .we_n_i(we), .data_i(dout),
      .data_o(din));
   // ***************************
   // Clock, timeout, report
   // ***************************
   initial forever #50 clk = ~clk;
   // Ceiling well above the fewer than one hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         complete_run();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (e !== g) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ***************************
   // Scenarios
   // ***************************
   task automatic acc(logic w, logic [1:0] s, logic [15:0] d);
      int n;
      @(posedge clk);
      #1 n = 0;
      // Raise the request only once ready stands
      while (rdy !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1 n++;
      end
      chk("ready", 16'h1, 16'(rdy));
      {req, wr, sp, wd} = {1'b1, w, s, d};
      @(posedge clk);
      #1 req = 0;
      chk("sel", 16'(3'h7 ^ (3'h4 >> s)), {ps, ds, is});
      chk("bus_cycle_strobe_n", 0, st);
      chk("rw", !w, rw);
      chk("wr_qual", w, go);
      @(posedge clk);
      #1 chk("rd", w, rd);
      chk("we", !w, we);
      chk("doe", w, doe);
      if (w) chk("dout", d, dout);
      repeat (2) @(posedge clk);
      #1 chk("done", 16'h6, {st, done, doe});
      if (!w && s != 2'h3) chk("rdat", d, rdat);
   endtask
   task automatic idle_levels();
      chk("idle", 16'h3f, {ps, ds, is, st, rw, rd});
      chk("idle_we_qual", 16'h5, {we, go, goe});
   endtask
   task automatic float_modes();
      for (int k = 0; k < 8; k++) begin
         {e1, trst, e0} = 3'(k);
         repeat (3) @(posedge clk);
         #1 chk("ctl_oe", k != 1, coe);
      end
      // Test reset back low for normal running
      {e1, trst, e0} = 3'h4;
   endtask
   task automatic gpio_pin_use();
      {mode, pin} = 2'h3;
      repeat (2) @(posedge clk);
      #1 chk("gpio_in", 16'h1, {goe, gin});
      {dir, gout} = 2'h3;
      repeat (2) @(posedge clk);
      #1 chk("gpio_out", 16'h3, {goe, go});
      // Mid-run reset: the shared pin must fall back to input
      rst = 1;
      #1 chk("gpio_reset", 16'h0, {goe, go});
      {mode, dir} = 2'h0;
      @(posedge clk);
      #1 rst = 0;
      repeat (2) @(posedge clk);
      #1 idle_levels();
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 0;
      repeat (2) @(posedge clk);
      #1 idle_levels();
      for (int s = 0; s < 4; s++) acc(1, 2'(s), 16'ha5c0 ^ 16'(s));
      for (int s = 0; s < 4; s++) acc(0, 2'(s), 16'ha5c0 ^ 16'(s));
      float_modes();
      gpio_pin_use();
      complete_run();
   end
endmodule
